// *** src/abt_pkg.sv ***
package abt_pkg;

  // ----------------------------------------------------------------
  // clock and bus widths
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int DAL_W = 22;
  localparam int DATA_W = 16;
  localparam int LEN_W = 8;
  localparam int CNT_W = 12;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // line positions on the multiplexed lines
  // ----------------------------------------------------------------
  localparam int BYTE_SEL_BIT = 0;
  localparam int PERR_BIT = 16;
  localparam int PERR_EN_BIT = 17;
  localparam int EXT_LSB = 18;
  localparam int IO_PAGE_LSB = 13;

  // ----------------------------------------------------------------
  // bus timing in ns and derived cycle counts
  // ----------------------------------------------------------------
  localparam int T_SETUP_NS = 75;
  localparam int T_STROBE_NS = 100;
  localparam int T_DESKEW_NS = 200;
  localparam int T_WHOLD_NS = 150;
  localparam int T_FRAME_NS = 175;
  localparam int T_IDLE_NS = 300;
  localparam int T_TIMEOUT_NS = 10000;

  // least times round up
  localparam int C_SETUP = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int C_STROBE = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int C_DESKEW = (T_DESKEW_NS * CLK_MHZ + 999) / 1000;
  localparam int C_WHOLD = (T_WHOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int C_FRAME = (T_FRAME_NS * CLK_MHZ + 999) / 1000;
  localparam int C_IDLE = (T_IDLE_NS * CLK_MHZ + 999) / 1000;
  // a longest time rounds down
  localparam int C_TIMEOUT = (T_TIMEOUT_NS * CLK_MHZ) / 1000;

  // ----------------------------------------------------------------
  // cycle kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    K_WORD_READ = 3'h0,
    K_WORD_WRITE = 3'h1,
    K_BYTE_WRITE = 3'h2,
    K_WORD_RMW = 3'h3,
    K_WORD_READ_BYTE_WRITE = 3'h4,
    K_BLOCK_READ = 3'h5,
    K_BLOCK_WRITE = 3'h6
  } abt_kind_t;

  function automatic logic kind_reads_first(input abt_kind_t k);
    return (k == K_WORD_READ) || (k == K_WORD_RMW) ||
           (k == K_WORD_READ_BYTE_WRITE) || (k == K_BLOCK_READ);
  endfunction

  function automatic logic kind_is_rmw(input abt_kind_t k);
    return (k == K_WORD_RMW) || (k == K_WORD_READ_BYTE_WRITE);
  endfunction

  function automatic logic kind_is_block(input abt_kind_t k);
    return (k == K_BLOCK_READ) || (k == K_BLOCK_WRITE);
  endfunction

  function automatic logic in_io_page(input logic [DAL_W-1:0] a);
    return &a[DAL_W-1:IO_PAGE_LSB];
  endfunction

endpackage

// *** src/abt_stream_if.sv ***
`timescale 1ns/1ns
interface abt_stream_if #(
  parameter int W = 16
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** src/abt_sync.sv ***
`timescale 1ns/1ns
module abt_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// *** src/abt_fifo.sv ***
`timescale 1ns/1ns
module abt_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // streams
  abt_stream_if.snk in_s,
  abt_stream_if.src out_s
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_s.ready = (count != DEPTH_C);
  assign out_s.valid = (count != '0);
  assign out_s.data = mem[rp];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_comb begin
    next_wp = wp;
    next_rp = rp;
    next_count = count;
    if (push) begin
      next_wp = (wp == LAST_C) ? '0 : wp + 1'b1;
    end
    if (pop) begin
      next_rp = (rp == LAST_C) ? '0 : rp + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      count <= next_count;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (push) begin
      mem[wp] <= in_s.data;
    end
  end

endmodule

// *** src/abt_master.sv ***
`timescale 1ns/1ns
// How it works
// - each plain read, write or byte cycle moves one word or one byte between master and slave; the two rmw kinds read a word, then write a word or byte
// - block mode sends one address then strobes consecutive words
// - seven cycle kinds: read, write, byte, two rmw, block read, write
// - low sixteen lines carry word and byte data
// - lines 16,17 extend address, then carry parity error and enable
// - upper four lines carry extended address beyond first 256 Kbytes
// - cycle frame asserted from the end of address setup until the transaction ends
// - io page select asserted when the address lies in the io page
// - each transaction is between master and one addressed slave
// - start only when bus granted and previous frame negated
// - address phase drives slave address onto multiplexed lines
// - abort the cycle when no reply arrives within 10 us
// - write byte control at address setup marks output cycles
module abt_master #(
  parameter int TIMEOUT_CYC = abt_pkg::C_TIMEOUT,
  parameter int FIFO_DEPTH = abt_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [2:0] cmd_kind,
  input wire logic [abt_pkg::DAL_W-1:0] cmd_addr,
  input wire logic [abt_pkg::LEN_W-1:0] cmd_len,
  // write data
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [abt_pkg::DATA_W-1:0] wr_data,
  // read data
  output logic rd_valid,
  output logic [abt_pkg::DATA_W-1:0] rd_data,
  output logic rd_perr,
  // status
  output logic busy,
  output logic done,
  output logic timeout_err,
  // arbitration
  input wire logic bus_grant,
  // multiplexed lines
  input wire logic [abt_pkg::DAL_W-1:0] dal_in,
  output logic [abt_pkg::DAL_W-1:0] dal_out,
  output logic dal_oe,
  // cycle frame
  input wire logic frame_in,
  output logic frame_out,
  output logic frame_oe,
  // strobes and controls
  output logic read_strobe,
  output logic write_strobe,
  output logic write_byte_ctl,
  output logic io_page_select,
  input wire logic slave_reply
);

  // ----------------------------------------------------------------
  // types and constants
  // ----------------------------------------------------------------
  localparam int DW = abt_pkg::DATA_W;
  localparam int AW = abt_pkg::DAL_W;
  localparam int CW = abt_pkg::CNT_W;
  localparam logic [CW-1:0] C_SETUP = CW'(abt_pkg::C_SETUP);
  localparam logic [CW-1:0] C_STROBE = CW'(abt_pkg::C_STROBE);
  localparam logic [CW-1:0] C_DESKEW = CW'(abt_pkg::C_DESKEW);
  localparam logic [CW-1:0] C_WHOLD = CW'(abt_pkg::C_WHOLD);
  localparam logic [CW-1:0] C_FRAME = CW'(abt_pkg::C_FRAME);
  localparam logic [CW-1:0] C_IDLE = CW'(abt_pkg::C_IDLE);
  localparam logic [CW-1:0] C_TOUT = CW'(TIMEOUT_CYC);

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_ADDR = 4'h1,
    S_AHOLD = 4'h2,
    S_RWAIT = 4'h3,
    S_RDSK = 4'h4,
    S_RREL = 4'h5,
    S_WLOAD = 4'h6,
    S_WSET = 4'h7,
    S_WWAIT = 4'h8,
    S_WDSK = 4'h9,
    S_WREL = 4'hA,
    S_END = 4'hB
  } abt_state_t;

  // ----------------------------------------------------------------
  // handshake synchronisers and write data buffer
  // ----------------------------------------------------------------
  logic reply_s;
  logic frame_s;

  abt_sync #(.W(2)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d({slave_reply, frame_in}),
    .q({reply_s, frame_s})
  );

  abt_stream_if #(.W(DW)) wr_in ();
  abt_stream_if #(.W(DW)) wr_out ();

  assign wr_in.valid = wr_valid;
  assign wr_in.data = wr_data;
  assign wr_ready = wr_in.ready;

  abt_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_s(wr_in),
    .out_s(wr_out)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  abt_state_t st, next_st;
  abt_pkg::abt_kind_t kind, next_kind;
  logic [CW-1:0] cnt, next_cnt;
  logic [abt_pkg::LEN_W-1:0] left, next_left;
  logic [AW-1:0] next_dal_out;
  logic next_dal_oe, next_frame, next_rstb, next_wstb;
  logic next_wbt, next_iosel;
  logic [DW-1:0] next_rd_data;
  logic next_rd_valid, next_rd_perr, next_done, next_terr;
  logic start;

  // bus idle and granted before a new cycle may open
  assign cmd_ready = (st == S_IDLE) && (cnt == '0) && bus_grant &&
                     !frame_s;
  assign start = cmd_valid && cmd_ready;
  assign wr_out.ready = (st == S_WLOAD);
  assign frame_oe = frame_out;
  assign busy = (st != S_IDLE);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_kind = kind;
    next_cnt = cnt;
    next_left = left;
    next_dal_out = dal_out;
    next_dal_oe = dal_oe;
    next_frame = frame_out;
    next_rstb = read_strobe;
    next_wstb = write_strobe;
    next_wbt = write_byte_ctl;
    next_iosel = io_page_select;
    next_rd_data = rd_data;
    next_rd_valid = 1'b0;
    next_rd_perr = rd_perr;
    next_done = 1'b0;
    next_terr = 1'b0;
    case (st)
      S_IDLE: begin
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end
        if (start) begin
          next_kind = abt_pkg::abt_kind_t'(cmd_kind);
          next_left = (cmd_len == '0) ?
                      {{(abt_pkg::LEN_W-1){1'b0}}, 1'b1} : cmd_len;
          // full address incl. extension lines
          next_dal_out = cmd_addr;
          next_dal_oe = 1'b1;
          next_iosel = abt_pkg::in_io_page(cmd_addr);
          // output kinds announced at address setup
          next_wbt = !abt_pkg::kind_reads_first(
                       abt_pkg::abt_kind_t'(cmd_kind));
          next_cnt = C_SETUP;
          next_st = S_ADDR;
        end
      end
      S_ADDR: begin
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else begin
          // frame edge selects one slave for the cycle
          next_frame = 1'b1;
          next_cnt = C_STROBE;
          next_st = S_AHOLD;
        end
      end
      S_AHOLD: begin
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else begin
          next_dal_oe = 1'b0;
          next_iosel = 1'b0;
          next_wbt = (kind == abt_pkg::K_BYTE_WRITE);
          if (abt_pkg::kind_reads_first(kind)) begin
            next_rstb = 1'b1;
            next_cnt = C_TOUT;
            next_st = S_RWAIT;
          end else begin
            next_st = S_WLOAD;
          end
        end
      end
      S_RWAIT: begin
        if (reply_s) begin
          next_cnt = C_DESKEW;
          next_st = S_RDSK;
        end else if (cnt == '0) begin
          next_rstb = 1'b0;
          next_terr = 1'b1;
          next_st = S_END;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      S_RDSK: begin
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else begin
          next_rd_data = dal_in[DW-1:0];
          next_rd_perr = dal_in[abt_pkg::PERR_BIT] &
                         dal_in[abt_pkg::PERR_EN_BIT];
          next_rd_valid = 1'b1;
          next_rstb = 1'b0;
          next_st = S_RREL;
        end
      end
      S_RREL: begin
        if (!reply_s) begin
          if (abt_pkg::kind_is_rmw(kind)) begin
            // frame stays on, same slave gets the write
            next_wbt = (kind == abt_pkg::K_WORD_READ_BYTE_WRITE);
            next_st = S_WLOAD;
          end else if (abt_pkg::kind_is_block(kind) &&
                       left > 1'b1) begin
            // next word, no new address phase
            next_left = left - 1'b1;
            next_rstb = 1'b1;
            next_cnt = C_TOUT;
            next_st = S_RWAIT;
          end else begin
            next_st = S_END;
          end
        end
      end
      S_WLOAD: begin
        if (wr_out.valid) begin
          next_dal_out = {{(AW-DW){1'b0}}, wr_out.data};
          next_dal_oe = 1'b1;
          next_cnt = C_DESKEW;
          next_st = S_WSET;
        end
      end
      S_WSET: begin
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else begin
          next_wstb = 1'b1;
          next_cnt = C_TOUT;
          next_st = S_WWAIT;
        end
      end
      S_WWAIT: begin
        if (reply_s) begin
          next_cnt = C_WHOLD;
          next_st = S_WDSK;
        end else if (cnt == '0) begin
          next_wstb = 1'b0;
          next_terr = 1'b1;
          next_st = S_END;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      S_WDSK: begin
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else begin
          next_wstb = 1'b0;
          next_cnt = C_FRAME;
          next_st = S_WREL;
        end
      end
      S_WREL: begin
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else if (!reply_s) begin
          next_dal_oe = 1'b0;
          if (kind == abt_pkg::K_BLOCK_WRITE && left > 1'b1) begin
            next_left = left - 1'b1;
            next_st = S_WLOAD;
          end else begin
            next_st = S_END;
          end
        end
      end
      S_END: begin
        next_frame = 1'b0;
        next_dal_oe = 1'b0;
        next_wbt = 1'b0;
        next_iosel = 1'b0;
        next_done = 1'b1;
        next_cnt = C_IDLE;
        next_st = S_IDLE;
      end
      default: begin
        next_st = S_IDLE;
        next_frame = 1'b0;
        next_rstb = 1'b0;
        next_wstb = 1'b0;
        next_dal_oe = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= S_IDLE;
      kind <= abt_pkg::K_WORD_READ;
      cnt <= '0;
      left <= '0;
      dal_out <= '0;
      dal_oe <= 1'b0;
      frame_out <= 1'b0;
      read_strobe <= 1'b0;
      write_strobe <= 1'b0;
      write_byte_ctl <= 1'b0;
      io_page_select <= 1'b0;
      rd_data <= '0;
      rd_valid <= 1'b0;
      rd_perr <= 1'b0;
      done <= 1'b0;
      timeout_err <= 1'b0;
    end else begin
      st <= next_st;
      kind <= next_kind;
      cnt <= next_cnt;
      left <= next_left;
      dal_out <= next_dal_out;
      dal_oe <= next_dal_oe;
      frame_out <= next_frame;
      read_strobe <= next_rstb;
      write_strobe <= next_wstb;
      write_byte_ctl <= next_wbt;
      io_page_select <= next_iosel;
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      rd_perr <= next_rd_perr;
      done <= next_done;
      timeout_err <= next_terr;
    end
  end

endmodule

// *** tb/abt_master_checker.sv ***
`timescale 1ns/1ns
module abt_master_checker #(
  parameter int TIMEOUT_CYC = 2500
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // command and status
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [2:0] cmd_kind,
  input wire logic bus_grant,
  input wire logic busy,
  input wire logic done,
  input wire logic timeout_err,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic rd_perr,
  // bus
  input wire logic [21:0] dal_in,
  input wire logic [21:0] dal_out,
  input wire logic dal_oe,
  input wire logic frame_in,
  input wire logic frame_out,
  input wire logic frame_oe,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic write_byte_ctl,
  input wire logic io_page_select,
  input wire logic slave_reply
);
  logic is_wr;
  logic [15:0] hang;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // kind of the command in flight, and cycles a strobe waits unanswered
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      is_wr <= 1'b0;
      hang <= 16'h0;
    end else begin
      if (cmd_valid && cmd_ready) begin
        is_wr <= cmd_kind inside {3'h1, 3'h2, 3'h6};
      end
      if ((read_strobe || write_strobe) && !slave_reply) begin
        hang <= hang + 16'h1;
      end else begin
        hang <= 16'h0;
      end
    end
  end
  frame_when_busy_a: assert property (frame_out |-> busy)
    else $error("frame without transaction");
  one_strobe_a: assert property ((read_strobe || write_strobe) |->
    frame_out && !(read_strobe && write_strobe))
    else $error("strobe outside frame or both strobes");
  start_when_free_a: assert property (cmd_valid && cmd_ready |->
    bus_grant && !frame_in && !busy)
    else $error("command taken while bus not free");
  addr_setup_a: assert property ($rose(frame_out) |->
    dal_oe && $stable(dal_out) && $past(dal_oe, 8))
    else $error("address not set up before frame");
  io_select_a: assert property ($rose(frame_out) |->
    io_page_select == (&dal_out[21:13]))
    else $error("io select wrong at frame");
  write_ctl_a: assert property ($rose(frame_out) |->
    write_byte_ctl == is_wr)
    else $error("write control wrong at frame");
  read_reply_a: assert property (rd_valid |->
    $past(slave_reply, 3) && rd_data == $past(dal_in[15:0]))
    else $error("read data not taken from replied lines");
  read_parity_a: assert property (rd_valid |->
    rd_perr == ($past(dal_in[16]) && $past(dal_in[17])))
    else $error("parity flag wrong");
  write_hold_a: assert property ($fell(write_strobe) && !timeout_err |->
    $past(slave_reply, 2) && dal_oe)
    else $error("write strobe dropped before reply");
  write_data_a: assert property (write_strobe |->
    dal_oe && $stable(dal_out))
    else $error("write data not stable under strobe");
  frame_end_a: assert property ($fell(frame_out) |->
    !$past(slave_reply, 2) && !read_strobe && !write_strobe)
    else $error("frame dropped too early");
  reply_bound_a: assert property (hang <= TIMEOUT_CYC + 4)
    else $error("strobe held past timeout");
  abort_done_a: assert property (timeout_err |=>
    done && !read_strobe && !write_strobe)
    else $error("timeout did not end cycle");
  frame_drive_a: assert property (frame_oe == frame_out)
    else $error("frame enable differs from frame level");
  read_release_a: assert property (read_strobe |-> !dal_oe)
    else $error("master drives lines during read strobe");
endmodule
bind abt_master abt_master_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.*);

// *** tb/abt_slave.sv ***
`timescale 1ns/1ns
module abt_slave (
  // clock
  input wire logic sys_clk,
  // bus from master
  input wire logic frame,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic write_byte_ctl,
  input wire logic io_page_select,
  input wire logic [21:0] dal,
  // test controls
  input wire logic mute,
  input wire logic perr,
  input wire logic [7:0] dly,
  // answer
  output logic slave_reply,
  output logic [21:0] sl_dal
);
  logic [15:0] mem [0:15];
  logic [21:0] adr;
  logic [21:0] wx;
  logic frame_q, moved, last_wr, wr_now;
  int n;
  // write after a read in one frame goes back to the read word
  assign wx = (moved && !last_wr) ? adr - 22'h2 : adr;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'hA000 + 16'(i);
    slave_reply = 1'b0;
    sl_dal = 22'h0;
    frame_q = 1'b0;
    n = 0;
  end
  always @(posedge sys_clk) begin
    frame_q <= frame;
    if (!slave_reply) sl_dal <= ~sl_dal;
    if (frame && !frame_q) begin
      adr <= io_page_select ? {9'h0, dal[12:0]} : dal;
      moved <= 1'b0;
    end
    if ((read_strobe || write_strobe) && !slave_reply && !mute) begin
      n <= n + 1;
      if (n >= dly) begin
        n <= 0;
        slave_reply <= 1'b1;
        wr_now <= write_strobe;
        if (read_strobe) sl_dal <= {perr, perr, mem[adr[4:1]]};
        if (write_strobe && !(write_byte_ctl && wx[0]))
          mem[wx[4:1]][7:0] <= dal[7:0];
        if (write_strobe && !(write_byte_ctl && !wx[0]))
          mem[wx[4:1]][15:8] <= dal[15:8];
      end
    end else if (!read_strobe && !write_strobe && slave_reply) begin
      slave_reply <= 1'b0;
      adr <= adr + 22'h2;
      moved <= 1'b1;
      last_wr <= wr_now;
    end
  end
endmodule

// *** tb/abt_master_tb.sv ***
`timescale 1ns/1ns
module abt_master_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, rd_perr;
  logic busy, done, timeout_err, bus_grant, dal_oe, frame_out, mute, perr;
  logic read_strobe, write_strobe, write_byte_ctl, io_page_select;
  logic slave_reply, tmo, fr_seen, io_any, perr_seen;
  logic [2:0] cmd_kind;
  logic [7:0] cmd_len, dly;
  logic [15:0] wr_data, rd_data;
  logic [21:0] cmd_addr, dal_in, dal_out, sl_dal, adr_seen;
  logic [15:0] got [$];
  int errors = 0;
  int num_checks = 0;
  assign dal_in = dal_oe ? dal_out : sl_dal;
  always #2 sys_clk = ~sys_clk;
  abt_master #(.TIMEOUT_CYC(40)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_perr(rd_perr), .busy(busy), .done(done),
    .timeout_err(timeout_err), .bus_grant(bus_grant), .dal_in(dal_in),
    .dal_out(dal_out), .dal_oe(dal_oe), .frame_in(frame_out),
    .frame_out(frame_out), .frame_oe(), .read_strobe(read_strobe),
    .write_strobe(write_strobe), .write_byte_ctl(write_byte_ctl),
    .io_page_select(io_page_select), .slave_reply(slave_reply));
  abt_slave u_slave (.sys_clk(sys_clk), .frame(frame_out),
    .read_strobe(read_strobe), .write_strobe(write_strobe),
    .write_byte_ctl(write_byte_ctl), .io_page_select(io_page_select),
    .dal(dal_in), .mute(mute), .perr(perr), .dly(dly),
    .slave_reply(slave_reply), .sl_dal(sl_dal));
  task automatic stop_test();
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [21:0] seen,
    input logic [21:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic push(input logic [15:0] d);
    @(negedge sys_clk);
    wr_valid = 1'b1;
    wr_data = d;
    while (wr_ready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    wr_valid = 1'b0;
  endtask
  // one command to its done pulse, gathering what the bus showed
  task automatic run(input logic [2:0] k, input logic [21:0] a,
    input logic [7:0] n);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_addr = a;
    cmd_len = n;
    while (cmd_ready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    got.delete();
    tmo = 1'b0;
    fr_seen = 1'b0;
    while (done !== 1'b1) begin
      if (frame_out === 1'b1 && !fr_seen) begin
        fr_seen = 1'b1;
        adr_seen = dal_in;
        io_any = io_page_select;
      end
      if (rd_valid === 1'b1) got.push_back(rd_data);
      if (rd_valid === 1'b1) perr_seen = rd_perr;
      if (timeout_err === 1'b1) tmo = 1'b1;
      @(negedge sys_clk);
    end
  endtask
  task automatic t_read();
    run(3'h0, 22'h000010, 8'h1);
    check("read word", got[0], 22'h00A008);
    check("read count", got.size(), 22'h1);
    check("addr phase", adr_seen, 22'h000010);
    run(3'h0, 22'h3FE004, 8'h1);
    check("io data", got[0], 22'h00A002);
    check("io select", io_any, 22'h1);
    run(3'h0, 22'h3C0006, 8'h1);
    check("ext addr", adr_seen, 22'h3C0006);
    check("ext select", io_any, 22'h0);
  endtask
  task automatic t_write();
    push(16'h1234);
    run(3'h1, 22'h00000C, 8'h1);
    run(3'h0, 22'h00000C, 8'h1);
    check("word write", got[0], 22'h001234);
    push(16'hBE00);
    run(3'h2, 22'h00000D, 8'h1);
    push(16'h0099);
    run(3'h2, 22'h00000C, 8'h1);
    run(3'h0, 22'h00000C, 8'h1);
    check("byte merge", got[0], 22'h00BE99);
  endtask
  task automatic t_rmw();
    push(16'h5555);
    run(3'h3, 22'h000004, 8'h1);
    check("rmw old", got[0], 22'h00A002);
    push(16'h7700);
    run(3'h4, 22'h000005, 8'h1);
    check("rmwb old", got[0], 22'h005555);
    run(3'h0, 22'h000004, 8'h1);
    check("rmwb new", got[0], 22'h007755);
  endtask
  task automatic t_fault();
    perr = 1'b1;
    run(3'h0, 22'h000010, 8'h1);
    perr = 1'b0;
    check("parity", perr_seen, 22'h1);
    mute = 1'b1;
    run(3'h0, 22'h000010, 8'h1);
    check("timeout", tmo, 22'h1);
    check("no data", got.size(), 22'h0);
    push(16'h0F0F);
    run(3'h1, 22'h000010, 8'h1);
    mute = 1'b0;
    check("write timeout", tmo, 22'h1);
    check("fifo drained", wr_ready, 22'h1);
    bus_grant = 1'b0;
    repeat (100) @(negedge sys_clk);
    check("no grant", cmd_ready, 22'h0);
    bus_grant = 1'b1;
  endtask
  task automatic t_block();
    @(negedge sys_clk);
    wr_valid = 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr_data = 16'hB000 + 16'(i);
      while (wr_ready !== 1'b1) @(negedge sys_clk);
      @(negedge sys_clk);
    end
    wr_valid = 1'b0;
    check("fifo full", wr_ready, 22'h0);
    dly = 8'd30;
    run(3'h6, 22'h000010, 8'h8);
    check("fifo empty", wr_ready, 22'h1);
    run(3'h5, 22'h000010, 8'h8);
    dly = 8'd2;
    check("block count", got.size(), 22'h8);
    for (int i = 0; i < 8; i++) begin
      check("block word", got[i], 22'hB000 + 22'(i));
    end
  endtask
  initial begin
    #200000;
    errors++;
    stop_test();
  end
  initial begin
    {cmd_valid, wr_valid, mute, perr} = 4'h0;
    bus_grant = 1'b1;
    cmd_kind = 3'h0;
    cmd_addr = 22'h0;
    cmd_len = 8'h1;
    wr_data = 16'h0;
    dly = 8'd2;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    t_read();
    t_write();
    t_rmw();
    t_fault();
    t_block();
    stop_test();
  end
endmodule
